// File: rtl/dim_irq_mux_timers.sv
// Dual interrupt multiplexer with event counter and cascaded timer
`timescale 1ns/1ps
module dim_irq_mux_timers
    import dim_pkg::*;
#(
    parameter int TIMER_DIV_P = TIMER_DIV,
    parameter bit SINGLE_GROUP = 1'b0
)
(
    input wire logic ref_clk,
    input wire logic nrst,
    input wire dim_io_req_t io_req,
    output logic [7:0] io_rdata,
    input wire dim_portc_t grp1_portc,
    input wire dim_portc_t grp2_portc,
    input wire logic event_count_input,
    input wire logic event_edge_rising,
    output logic inta_n_out,
    output logic inta_n_oe,
    output logic [1:0] irq_pending
);

    localparam int DW = (TIMER_DIV_P > 2) ? $clog2(TIMER_DIV_P) : 1;
    localparam logic [DW-1:0] DIV_LAST = DW'(TIMER_DIV_P - 1);

    if (TIMER_DIV_P < 2)
    begin : g_bad_div
        $error("TIMER_DIV_P must be at least 2");
    end

    logic [3:0] isc_q;
    logic [1:0] pend_q;
    logic [1:0] req_ev;
    logic [1:0] clr;
    logic [1:0] src_out;
    logic [1:0] src_prev_q;
    logic [2:0] tick;
    logic [2:0] cnt_out;
    logic [2:0] data_wr_sel;
    logic [2:0] ctrl_wr_sel;
    logic [2:0] rd_sel;
    logic [7:0] cnt_rdata [3];
    logic [7:0] cnt_status [3];
    logic [7:0] rd_mux;
    logic [1:0] status_sel_q;
    logic [DW-1:0] div_q;
    logic evt_q;
    logic out1_q;
    dim_portc_t portc [2];
    dim_portc_t portc_q [2];
    logic is_cw_wr;
    logic is_readback;

    assign portc[0] = grp1_portc;
    assign portc[1] = grp2_portc;
    // Counter zero feeds request one, the chained timer request two
    assign src_out[0] = cnt_out[0];
    assign src_out[1] = cnt_out[2];

    // 2 MHz reference for the chained timer
    always_ff @(posedge ref_clk)
    begin
        if (!nrst)
            div_q <= '0;
        else if (div_q == DIV_LAST)
            div_q <= '0;
        else
            div_q <= div_q + DW'(1);
    end

    always_ff @(posedge ref_clk)
    begin
        if (!nrst)
        begin
            // Tracks the pin in reset too, so release shows no false edge
            evt_q <= event_count_input;
            out1_q <= 1'b1;
        end
        else
        begin
            evt_q <= event_count_input;
            out1_q <= cnt_out[1];
        end
    end

    always_comb
    begin
        // Only the chosen edge of the event line advances counter zero
        tick[0] = event_edge_rising ?
            (event_count_input && !evt_q) :
            (!event_count_input && evt_q);
        tick[1] = div_q == DIV_LAST;
        // Second counter runs off the first one's output edge
        tick[2] = cnt_out[1] && !out1_q;
    end

    always_comb
    begin
        is_cw_wr = io_req.wr && io_req.addr == OFS_CNT_CTRL;
        is_readback = io_req.wdata[CW_SEL_LSB +: 2] == CW_SEL_READBACK;
    end

    // Counters sit at three consecutive byte addresses
    for (genvar j = 0; j < 3; j++)
    begin : g_cnt
        assign data_wr_sel[j] = io_req.wr
            && io_req.addr == OFS_CNT0 + 8'(j);
        assign rd_sel[j] = io_req.rd && io_req.addr == OFS_CNT0 + 8'(j);
        assign ctrl_wr_sel[j] = is_cw_wr
            && io_req.wdata[CW_SEL_LSB +: 2] == 2'(j);

        dim_counter u_cnt (
            .ref_clk(ref_clk),
            .nrst(nrst),
            .tick(tick[j]),
            .gate(1'b1),
            .ctrl_wr(ctrl_wr_sel[j]),
            .data_wr(data_wr_sel[j]),
            .rd(rd_sel[j]),
            .wdata(io_req.wdata),
            .cnt_out(cnt_out[j]),
            .rdata(cnt_rdata[j]),
            .status(cnt_status[j])
        );
    end

    // Status read at the control address follows the last counter named by a control word
    always_ff @(posedge ref_clk)
    begin
        if (!nrst)
            status_sel_q <= 2'h0;
        else if (is_cw_wr && !is_readback)
            status_sel_q <= io_req.wdata[CW_SEL_LSB +: 2];
    end

    always_comb
    begin
        rd_mux = 8'h00;
        for (int k = 0; k < 3; k++)
        begin
            if (io_req.addr == OFS_CNT0 + 8'(k))
                rd_mux = cnt_rdata[k];
        end
        if (io_req.addr == OFS_CNT_CTRL)
            rd_mux = cnt_status[status_sel_q];
    end

    // Source select and clear are write only; they read as zero
    always_ff @(posedge ref_clk)
    begin
        if (!nrst)
            io_rdata <= 8'h00;
        else if (io_req.rd)
            io_rdata <= rd_mux;
    end

    always_ff @(posedge ref_clk)
    begin
        if (!nrst)
            isc_q <= ISC_RESET;
        else if (io_req.wr && io_req.addr == OFS_ISC)
            isc_q <= io_req.wdata[3:0];
    end

    always_comb
    begin
        clr[0] = io_req.wr && io_req.addr == OFS_CLR
            && io_req.wdata[CLR_REQ1_BIT];
        clr[1] = io_req.wr && io_req.addr == OFS_CLR
            && io_req.wdata[CLR_REQ2_BIT];
    end

    always_ff @(posedge ref_clk)
    begin
        if (!nrst)
        begin
            portc_q[0] <= '0;
            portc_q[1] <= '0;
            src_prev_q <= 2'b00;
        end
        else
        begin
            portc_q[0] <= portc[0];
            portc_q[1] <= portc[1];
            src_prev_q <= src_out;
        end
    end

    for (genvar i = 0; i < 2; i++)
    begin : g_req
        localparam int SEL_LSB = (i == 0) ? ISC_REQ1_LSB : ISC_REQ2_LSB;
        // Without the second port group only the timer can drive request 2
        localparam bit EXT_OK = !(SINGLE_GROUP && i == 1);
        dim_src_t sel;
        logic c0, c3, c0_q, c3_q;
        logic fall_ev, comb_ev, cnt_ev;

        always_comb
        begin
            sel = dim_src_t'(isc_q[SEL_LSB +: 2]);
            c0 = portc[i].portc_bit0;
            c3 = portc[i].portc_bit3;
            c0_q = portc_q[i].portc_bit0;
            c3_q = portc_q[i].portc_bit3;
            fall_ev = c0_q && !c0;
            // A C3 fall with C0 low, or a C0 rise with C3 high
            comb_ev = (!c0 && c3_q && !c3)
                || (!c0_q && c0 && c3);
            cnt_ev = src_out[i] && !src_prev_q[i];
            unique case (sel)
                DIM_SRC_OFF: req_ev[i] = 1'b0;
                DIM_SRC_FALL: req_ev[i] = EXT_OK && fall_ev;
                DIM_SRC_COMB: req_ev[i] = EXT_OK && comb_ev;
                DIM_SRC_CNT: req_ev[i] = cnt_ev;
            endcase
        end

        // A new event in the clearing cycle keeps the request pending
        always_ff @(posedge ref_clk)
        begin
            if (!nrst)
                pend_q[i] <= 1'b0;
            else
                pend_q[i] <= (pend_q[i] && !clr[i]) || req_ev[i];
        end
    end

    // Open-drain request line: driven low while anything pends
    assign inta_n_out = 1'b0;
    assign inta_n_oe = |pend_q;
    assign irq_pending = pend_q;

    // Cycles since the last 2 MHz reference pulse
    logic [DW-1:0] gap_q;
    always_ff @(posedge ref_clk)
    begin
        if (!nrst || tick[1])
            gap_q <= '0;
        else
            gap_q <= gap_q + DW'(1);
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!nrst);

    sequence s_cnt0_edge;
        cnt_out[0] && !src_prev_q[0];
    endsequence

    sequence s_timer_edge;
        cnt_out[2] && !src_prev_q[1];
    endsequence

    presc_period_a: assert property (
        tick[1] && $past(nrst) && $past(tick[1], 2) == 1'b0
        |-> $past(gap_q) == DIV_LAST - DW'(1))
        else $error("timer reference period is wrong");
    cascade_clk_a: assert property (
        $rose(cnt_out[1]) |-> tick[2] ##1 !tick[2])
        else $error("second counter not clocked by first output");
    event_edge_a: assert property (
        $rose(event_count_input) |-> tick[0] == event_edge_rising)
        else $error("event counter clocked on wrong edge");
    event_src_a: assert property (
        (isc_q[1:0] == 2'b11) and s_cnt0_edge |=> pend_q[0])
        else $error("event counter did not raise first request");
    timer_src_a: assert property (
        (isc_q[3:2] == 2'b11) and s_timer_edge |=> pend_q[1])
        else $error("timer did not raise second request");
    fall_src_a: assert property (
        isc_q[1:0] == 2'b01 && $fell(grp1_portc.portc_bit0) |=> pend_q[0])
        else $error("falling edge missed on first request");
    grp2_fall_a: assert property (
        !SINGLE_GROUP && isc_q[3:2] == 2'b01
        && $fell(grp2_portc.portc_bit0) |=> pend_q[1])
        else $error("falling edge missed on second request");
    comb_block_a: assert property (
        isc_q[1:0] == 2'b10 && !pend_q[0] && portc_q[0].portc_bit0
        && grp1_portc.portc_bit0 |=> !pend_q[0])
        else $error("combined mode fired while C0 high");
    comb_fire_a: assert property (
        isc_q[1:0] == 2'b10 && !grp1_portc.portc_bit0
        && $fell(grp1_portc.portc_bit3) |=> pend_q[0])
        else $error("combined mode missed C3 fall");
    comb_rise_a: assert property (
        isc_q[1:0] == 2'b10 && grp1_portc.portc_bit3
        && $rose(grp1_portc.portc_bit0) |=> pend_q[0])
        else $error("combined mode missed C0 rise");
    src_off_a: assert property (
        isc_q[1:0] == 2'b00 && !pend_q[0] |=> !pend_q[0])
        else $error("disabled first request became pending");
    single_grp_a: assert property (
        SINGLE_GROUP && isc_q[3] != isc_q[2] && !pend_q[1] |=> !pend_q[1])
        else $error("external source reached second request");
    set_wins_a: assert property (
        req_ev[0] && clr[0] |=> pend_q[0])
        else $error("event lost in clearing cycle");
    hold_a: assert property (
        pend_q[0] && !clr[0] |=> pend_q[0] [*1] ##0 irq_pending[0])
        else $error("first request dropped without a clear");
    clear_a: assert property (
        clr[1] && !req_ev[1] |=> !pend_q[1])
        else $error("clear did not drop second request");
    line_a: assert property (
        pend_q != 2'b00 |-> inta_n_oe && !inta_n_out ##1
        (pend_q == 2'b00 || inta_n_oe))
        else $error("pending request not on interrupt line");
    isc_wr_a: assert property (
        io_req.wr && io_req.addr == OFS_ISC
        |=> isc_q == $past(io_req.wdata[3:0]))
        else $error("source select not written");
    isc_rd_a: assert property (
        io_req.rd && io_req.addr == OFS_ISC |=> io_rdata == 8'h00)
        else $error("write-only register returned data");
    grp2_comb_a: assert property (
        !SINGLE_GROUP && isc_q[3:2] == 2'b10 && !grp2_portc.portc_bit0
        && $fell(grp2_portc.portc_bit3) |=> pend_q[1])
        else $error("combined mode missed C3 fall on second request");
    grp2_rise_a: assert property (
        !SINGLE_GROUP && isc_q[3:2] == 2'b10 && grp2_portc.portc_bit3
        && $rose(grp2_portc.portc_bit0) |=> pend_q[1])
        else $error("combined mode missed C0 rise on second request");
    fall_only_a: assert property (
        isc_q[1:0] == 2'b01 && !pend_q[0]
        && !$fell(grp1_portc.portc_bit0) |=> !pend_q[0])
        else $error("first request set without a falling edge");
    fall2_only_a: assert property (
        isc_q[3:2] == 2'b01 && !pend_q[1]
        && !$fell(grp2_portc.portc_bit0) |=> !pend_q[1])
        else $error("second request set without a falling edge");
    src2_off_a: assert property (
        isc_q[3:2] == 2'b00 && !pend_q[1] |=> !pend_q[1])
        else $error("disabled second request became pending");
    clear1_a: assert property (
        clr[0] && !req_ev[0] |=> !pend_q[0])
        else $error("clear did not drop first request");
    line_idle_a: assert property (
        pend_q == 2'b00 |-> !inta_n_oe)
        else $error("interrupt line driven with nothing pending");
    cascade_only_a: assert property (
        tick[2] |-> $rose(cnt_out[1]))
        else $error("second counter clocked without first output rise");
    ev_tick_a: assert property (
        tick[0] |-> $changed(event_count_input))
        else $error("event counter clocked without an input edge");

endmodule

// File: rtl/dim_pkg.sv
// Constants and types shared by the interrupt multiplexer and its counters
package dim_pkg;

    localparam logic [7:0] OFS_CNT0 = 8'h10;
    localparam logic [7:0] OFS_CNT_CTRL = 8'h13;
    localparam logic [7:0] OFS_ISC = 8'h20;
    localparam logic [7:0] OFS_CLR = 8'h30;

    localparam int REF_CLK_HZ = 200_000_000;
    localparam int TIMER_CLK_HZ = 2_000_000;
    localparam int TIMER_DIV = REF_CLK_HZ / TIMER_CLK_HZ;

    localparam logic [3:0] ISC_RESET = 4'h0;
    localparam int ISC_REQ1_LSB = 0;
    localparam int ISC_REQ2_LSB = 2;
    localparam int CLR_REQ1_BIT = 0;
    localparam int CLR_REQ2_BIT = 1;

    // Control word layout
    localparam int CW_SEL_LSB = 6;
    localparam int CW_RW_LSB = 4;
    localparam int CW_MODE_LSB = 1;
    localparam logic [1:0] CW_SEL_READBACK = 2'h3;

    typedef enum logic [2:0] {
        DIM_TERM_IRQ = 3'h0,
        DIM_ONE_SHOT = 3'h1,
        DIM_RATE_GEN = 3'h2,
        DIM_SQUARE = 3'h3,
        DIM_SW_STROBE = 3'h4,
        DIM_HW_STROBE = 3'h5
    } dim_cmode_t;

    typedef enum logic [1:0] {
        DIM_RW_LATCH = 2'h0,
        DIM_RW_LSB = 2'h1,
        DIM_RW_MSB = 2'h2,
        DIM_RW_BOTH = 2'h3
    } dim_rw_t;

    typedef enum logic [1:0] {
        DIM_SRC_OFF = 2'h0,
        DIM_SRC_FALL = 2'h1,
        DIM_SRC_COMB = 2'h2,
        DIM_SRC_CNT = 2'h3
    } dim_src_t;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } dim_io_req_t;

    typedef struct packed {
        logic portc_bit0;
        logic portc_bit3;
    } dim_portc_t;

endpackage

// File: rtl/dim_counter.sv
// One 16-bit down counter with six operating modes
`timescale 1ns/1ps
module dim_counter
    import dim_pkg::*;
(
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic tick,
    input wire logic gate,
    input wire logic ctrl_wr,
    input wire logic data_wr,
    input wire logic rd,
    input wire logic [7:0] wdata,
    output logic cnt_out,
    output logic [7:0] rdata,
    output logic [7:0] status
);

    dim_cmode_t mode_q;
    dim_rw_t rw_q;
    dim_rw_t cw_rw;
    dim_cmode_t cw_mode;
    logic [15:0] reload_q;
    logic [15:0] cnt_q;
    logic [15:0] latch_val_q;
    logic [15:0] rd_val;
    logic wr_hi_q, rd_hi_q, latched_q, load_pend_q, valid_q;
    logic armed_q, out_q, gate_q, trig_q;
    logic is_setup, write_done;

    always_comb
    begin
        cw_rw = dim_rw_t'(wdata[CW_RW_LSB +: 2]);
        // Codes 6 and 7 alias rate generator and square wave
        cw_mode = wdata[CW_MODE_LSB + 1] ?
            dim_cmode_t'({2'b01, wdata[CW_MODE_LSB]}) :
            dim_cmode_t'(wdata[CW_MODE_LSB +: 3]);
        is_setup = ctrl_wr && cw_rw != DIM_RW_LATCH;
        write_done = data_wr && (rw_q != DIM_RW_BOTH || wr_hi_q);
    end

    always_ff @(posedge ref_clk)
    begin
        if (!nrst)
        begin
            mode_q <= DIM_TERM_IRQ;
            rw_q <= DIM_RW_LSB;
        end
        else if (is_setup)
        begin
            mode_q <= cw_mode;
            rw_q <= cw_rw;
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (!nrst)
        begin
            reload_q <= 16'h0000;
            wr_hi_q <= 1'b0;
        end
        else if (is_setup)
            wr_hi_q <= 1'b0;
        else if (data_wr)
        begin
            unique case (rw_q)
                DIM_RW_LSB: reload_q <= {8'h00, wdata};
                DIM_RW_MSB: reload_q <= {wdata, 8'h00};
                default:
                    if (wr_hi_q)
                        reload_q[15:8] <= wdata;
                    else
                        reload_q[7:0] <= wdata;
            endcase
            wr_hi_q <= rw_q == DIM_RW_BOTH && !wr_hi_q;
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (!nrst)
        begin
            gate_q <= 1'b1;
            trig_q <= 1'b0;
        end
        else
        begin
            gate_q <= gate;
            trig_q <= (trig_q && !tick) || (gate && !gate_q);
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (!nrst)
        begin
            cnt_q <= 16'h0000;
            out_q <= 1'b1;
            armed_q <= 1'b0;
            load_pend_q <= 1'b0;
            valid_q <= 1'b0;
        end
        else if (is_setup)
        begin
            out_q <= cw_mode != DIM_TERM_IRQ;
            armed_q <= 1'b0;
            load_pend_q <= 1'b0;
            valid_q <= 1'b0;
        end
        else
        begin
            if (tick)
            begin
                unique case (mode_q)
                    DIM_TERM_IRQ, DIM_SW_STROBE:
                    begin
                        if (mode_q == DIM_SW_STROBE && !out_q)
                            out_q <= 1'b1;
                        if (load_pend_q)
                        begin
                            cnt_q <= reload_q;
                            load_pend_q <= 1'b0;
                            armed_q <= 1'b1;
                        end
                        else if (gate && armed_q)
                        begin
                            cnt_q <= cnt_q - 16'h0001;
                            if (cnt_q == 16'h0001)
                            begin
                                // Strobe fires once; terminal count stays up
                                out_q <= mode_q == DIM_TERM_IRQ;
                                armed_q <= mode_q == DIM_TERM_IRQ;
                            end
                        end
                    end
                    DIM_ONE_SHOT, DIM_HW_STROBE:
                    begin
                        if (mode_q == DIM_HW_STROBE && !out_q)
                            out_q <= 1'b1;
                        if (trig_q && valid_q)
                        begin
                            cnt_q <= reload_q;
                            armed_q <= 1'b1;
                            out_q <= mode_q == DIM_HW_STROBE;
                        end
                        else if (armed_q)
                        begin
                            cnt_q <= cnt_q - 16'h0001;
                            if (cnt_q == 16'h0001)
                            begin
                                armed_q <= 1'b0;
                                out_q <= mode_q == DIM_ONE_SHOT;
                            end
                        end
                    end
                    DIM_RATE_GEN, DIM_SQUARE:
                    begin
                        if (load_pend_q || (trig_q && valid_q))
                        begin
                            cnt_q <= (mode_q == DIM_SQUARE) ?
                                {reload_q[15:1], 1'b0} : reload_q;
                            load_pend_q <= 1'b0;
                            armed_q <= 1'b1;
                            out_q <= 1'b1;
                        end
                        else if (gate && armed_q && mode_q == DIM_SQUARE)
                        begin
                            // Odd counts run one input period short
                            if (cnt_q == 16'h0002)
                            begin
                                cnt_q <= {reload_q[15:1], 1'b0};
                                out_q <= !out_q;
                            end
                            else
                                cnt_q <= cnt_q - 16'h0002;
                        end
                        else if (gate && armed_q)
                        begin
                            if (cnt_q == 16'h0001)
                            begin
                                cnt_q <= reload_q;
                                out_q <= 1'b1;
                            end
                            else
                            begin
                                cnt_q <= cnt_q - 16'h0001;
                                out_q <= cnt_q != 16'h0002;
                            end
                        end
                    end
                    default:
                        armed_q <= 1'b0;
                endcase
            end
            if (write_done)
            begin
                load_pend_q <= 1'b1;
                valid_q <= 1'b1;
                if (mode_q == DIM_TERM_IRQ)
                    out_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (!nrst)
        begin
            rd_hi_q <= 1'b0;
            latched_q <= 1'b0;
            latch_val_q <= 16'h0000;
        end
        else if (is_setup)
        begin
            rd_hi_q <= 1'b0;
            latched_q <= 1'b0;
        end
        else if (ctrl_wr && !latched_q)
        begin
            latched_q <= 1'b1;
            latch_val_q <= cnt_q;
        end
        else if (rd)
        begin
            if (rw_q == DIM_RW_BOTH)
                rd_hi_q <= !rd_hi_q;
            if (rw_q != DIM_RW_BOTH || rd_hi_q)
                latched_q <= 1'b0;
        end
    end

    always_comb
    begin
        rd_val = latched_q ? latch_val_q : cnt_q;
        unique case (rw_q)
            DIM_RW_MSB: rdata = rd_val[15:8];
            DIM_RW_BOTH: rdata = rd_hi_q ? rd_val[15:8] : rd_val[7:0];
            default: rdata = rd_val[7:0];
        endcase
    end

    assign cnt_out = out_q;
    assign status = {out_q, load_pend_q, rw_q, mode_q, 1'b0};

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!nrst);

    term_zero_a: assert property (
        mode_q == DIM_TERM_IRQ && tick && gate && armed_q && !load_pend_q
        && cnt_q == 16'h0001 && !ctrl_wr && !data_wr |=> cnt_out)
        else $error("terminal count did not raise output");
    rate_low_a: assert property (
        mode_q == DIM_RATE_GEN && tick && gate && armed_q && !load_pend_q
        && !trig_q && cnt_q == 16'h0002 && !ctrl_wr |=> !cnt_out ##0
        cnt_q == 16'h0001)
        else $error("rate generator missed its low pulse");
    strobe_back_a: assert property (
        mode_q == DIM_SW_STROBE && !cnt_out && tick && !ctrl_wr
        |=> cnt_out)
        else $error("software strobe lasted over one input period");
    one_shot_a: assert property (
        mode_q == DIM_ONE_SHOT && tick && trig_q && valid_q && !ctrl_wr
        |=> !cnt_out && cnt_q == $past(reload_q))
        else $error("one-shot did not start on trigger");

endmodule

// File: verif/dim_line_model.sv
// External line model: port C bits of both groups and the one event input
`timescale 1ns/1ps
module dim_line_model
    import dim_pkg::*;
(
    input wire logic ref_clk,
    input wire logic [4:0] lreq,
    output dim_portc_t g1,
    output dim_portc_t g2,
    output logic ev
);
    // Lines move only just after an edge, as a slow field input would
    always_ff @(posedge ref_clk)
    begin
        g1 <= '{lreq[0], lreq[1]};
        g2 <= '{lreq[2], lreq[3]};
        ev <= lreq[4];
    end
endmodule

// File: verif/tb_top.sv
// Self-checking bench for the interrupt multiplexer and its counters
`timescale 1ns/1ps
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin \
    miscompares++; $display("wrong value %s exp %h got %h", n, e, g); end end
module tb_top;
    import dim_pkg::*;
    logic ref_clk = 1'b0;
    logic nrst = 1'b0;
    dim_io_req_t io_req = '0;
    logic [7:0] io_rdata;
    logic [7:0] lf = 8'h03;
    dim_portc_t g1, g2;
    logic ev, inta_n_out, inta_n_oe;
    logic [1:0] irq_pending;
    logic [1:0] exp_p = 2'h0;
    logic [4:0] lreq = 5'h0F;
    logic erise = 1'b1;
    int miscompares = 0, comparisons = 0, interrupt_source_select = 0;
    int iv[5] = '{5, 10, 6, 9, 0};
    logic [4:0] sv[6] = '{5'h0A, 5'h00, 5'h05, 5'h0F, 5'h0A, 5'h0F};
    initial
    begin
        forever #2.5 ref_clk = ~ref_clk;
    end
    dim_irq_mux_timers #(.TIMER_DIV_P(4), .SINGLE_GROUP(1'b0))
        dim_irq_mux_timers_i (.ref_clk(ref_clk), .nrst(nrst),
        .io_req(io_req), .io_rdata(io_rdata), .grp1_portc(g1),
        .grp2_portc(g2), .event_count_input(ev), .event_edge_rising(erise),
        .inta_n_out(inta_n_out), .inta_n_oe(inta_n_oe),
        .irq_pending(irq_pending));
    dim_line_model dim_line_model_i (.ref_clk(ref_clk), .lreq(lreq),
        .g1(g1), .g2(g2), .ev(ev));
    function automatic logic [7:0] nx(logic [7:0] x);
        return {x[6:0], x[7] ^ x[5] ^ x[4] ^ x[3]};
    endfunction
    function automatic logic fire(int s, logic o0, o3, n0, n3);
        case (s)
            1: return o0 & ~n0;
            2: return (~o0 & ~n0 & o3 & ~n3) | (~o0 & n0 & o3 & n3);
            default: return 1'b0;
        endcase
    endfunction
    task step(input int n);
        repeat (n) @(posedge ref_clk);
    endtask
    task chk;
        #1;
        `CHK("pending", exp_p, irq_pending)
        `CHK("line_oe", |exp_p, inta_n_oe)
        `CHK("line_out", 1'b0, inta_n_out)
        step(1);
    endtask
    task wr(input logic [7:0] a, input logic [7:0] d);
        io_req <= '{1'b1, 1'b0, a, d};
        step(1);
        io_req <= '0;
        step(1);
    endtask
    task rd0(input logic [7:0] a, input logic [7:0] e);
        io_req <= '{1'b0, 1'b1, a, 8'h00};
        step(1);
        io_req <= '0;
        step(1);
        #1;
        `CHK("rdata", e, io_rdata)
        step(1);
    endtask
    task si(input int v);
        lf = nx(lf);
        interrupt_source_select = v;
        // Upper nibble is random: the design must ignore it
        wr(OFS_ISC, {lf[7:4], 4'(v)});
    endtask
    task ln(input logic [4:0] v);
        exp_p[0] = exp_p[0] | fire(interrupt_source_select % 4, lreq[0], lreq[1], v[0], v[1]);
        exp_p[1] = exp_p[1] | fire(interrupt_source_select / 4, lreq[2], lreq[3], v[2], v[3]);
        lreq <= v;
        step(4);
        chk;
    endtask
    task clr(input logic [1:0] b);
        exp_p = exp_p & ~b;
        wr(OFS_CLR, {6'h00, b});
        chk;
    endtask
    task end_of_test;
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    initial
    begin
        step(4000);
        miscompares++;
        end_of_test;
    end
    initial
    begin
        step(20);
        nrst <= 1'b1;
        step(1);
        chk;
        rd0(OFS_ISC, 8'h00);
        rd0(8'h40, 8'h00);
        $display("reset test done");
        foreach (iv[i])
        begin
            si(iv[i]);
            foreach (sv[j])
                ln(sv[j]);
            clr(2'h1);
            clr(2'h2);
        end
        $display("source select test done");
        for (int e = 0; e < 2; e++)
        begin
            erise <= (e == 0);
            si(3);
            wr(OFS_CNT_CTRL, 8'h10);
            wr(OFS_CNT0, 8'h02);
            for (int k = 0; k < 3; k++)
            begin
                exp_p[0] = (k == 2) && (e == 0);
                ln(5'h1F);
                exp_p[0] = (k == 2);
                ln(5'h0F);
                if (k == 1)
                    rd0(OFS_CNT0, 8'h01);
            end
            rd0(OFS_CNT_CTRL, 8'h90);
            clr(2'h1);
        end
        $display("event counter test done");
        si(12);
        wr(OFS_CNT_CTRL, 8'h54);
        wr(8'h11, 8'h02);
        wr(OFS_CNT_CTRL, 8'h94);
        wr(8'h12, 8'h02);
        for (int n = 0; n < 300 && irq_pending[1] !== 1'b1; n++)
        begin
            step(1);
            #1;
        end
        exp_p[1] = 1'b1;
        chk;
        $display("timer test done");
        end_of_test;
    end
endmodule
